// ==== rtl/multiply_divide_unit.sv ====
// multiply/divide unit: result words, stall counter and read interlock
`timescale 1ns/1ps
module multiply_divide_unit (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // issue port
  input wire logic issue_valid,
  input wire logic [muldiv_pkg::OP_W-1:0] issue_op,
  input wire logic [muldiv_pkg::DATA_W-1:0] source_a_reg,
  input wire logic [muldiv_pkg::DATA_W-1:0] source_b_reg,
  // result read port
  input wire logic read_top_word,
  input wire logic read_bottom_word,
  output logic read_valid,
  output logic [muldiv_pkg::DATA_W-1:0] read_data,
  output logic read_stall,
  output logic busy
);
  import muldiv_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } state_t;

  // stall count for an operation
  function automatic logic [CNT_W-1:0] stall_of(input logic [OP_W-1:0] o);
    unique case (o)
      OP_SIGNED_WORD_PRODUCT, OP_UNSIGNED_WORD_PRODUCT:
        stall_of = STALL_WORD_PRODUCT;
      OP_SIGNED_DOUBLE_PRODUCT, OP_UNSIGNED_DOUBLE_PRODUCT:
        stall_of = STALL_DOUBLE_PRODUCT;
      OP_SIGNED_WORD_QUOTIENT, OP_UNSIGNED_WORD_QUOTIENT:
        stall_of = STALL_WORD_QUOTIENT;
      OP_SIGNED_DOUBLE_QUOTIENT, OP_UNSIGNED_DOUBLE_QUOTIENT:
        stall_of = STALL_DOUBLE_QUOTIENT;
      OP_HALFWORD_PRODUCT_ACCUMULATE, OP_HALFWORD_ACCUMULATE_BOTTOM_ONLY:
        stall_of = STALL_ACCUMULATE;
      default: stall_of = COUNT_RESET;
    endcase
  endfunction : stall_of

  state_t state_ff, nxt_state;
  logic [CNT_W-1:0] count_ff, nxt_count;
  logic [DATA_W-1:0] top_ff, nxt_top;
  logic [DATA_W-1:0] bottom_ff, nxt_bottom;
  logic [DATA_W-1:0] pend_top_ff, nxt_pend_top;
  logic [DATA_W-1:0] pend_bottom_ff, nxt_pend_bottom;
  logic read_valid_ff, nxt_read_valid;
  logic [DATA_W-1:0] read_data_ff, nxt_read_data;
  logic read_stall_ff, nxt_read_stall;
  logic busy_ff, nxt_busy;
  logic [DATA_W-1:0] calc_top;
  logic [DATA_W-1:0] calc_bottom;
  logic op_is_timed;
  logic finish;
  logic want_read;
  logic accept;

  // arithmetic core works on the committed result words
  muldiv_arith u_arith (
    .op(issue_op),
    .src_a(source_a_reg),
    .src_b(source_b_reg),
    .top_in(top_ff),
    .bottom_in(bottom_ff),
    .top_out(calc_top),
    .bottom_out(calc_bottom)
  );

  // an operation is not accepted while a previous one is in flight
  always_comb begin
    op_is_timed = (stall_of(issue_op) != COUNT_RESET);
    accept = issue_valid && (state_ff == ST_IDLE);
    finish = (state_ff == ST_RUN) && (count_ff == 7'd1);
    want_read = read_top_word || read_bottom_word;
  end

  // sequencer: result held pending, committed when the count runs out
  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_top = top_ff;
    nxt_bottom = bottom_ff;
    nxt_pend_top = pend_top_ff;
    nxt_pend_bottom = pend_bottom_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (accept && op_is_timed) begin
          nxt_state = ST_RUN;
          nxt_count = stall_of(issue_op);
          nxt_pend_top = calc_top;
          nxt_pend_bottom = calc_bottom;
        end else if (accept) begin
          nxt_top = calc_top;
          nxt_bottom = calc_bottom;
        end
      end
      ST_RUN: begin
        nxt_count = count_ff - 7'd1;
        if (finish) begin
          nxt_state = ST_IDLE;
          nxt_top = pend_top_ff;
          nxt_bottom = pend_bottom_ff;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_count = COUNT_RESET;
      end
    endcase
  end

  // read port: stalls while an operation runs short of its final cycle, else returns a word
  always_comb begin
    nxt_read_valid = 1'b0;
    nxt_read_data = read_data_ff;
    nxt_read_stall = 1'b0;
    nxt_busy = (nxt_state == ST_RUN);
    if (want_read && (state_ff == ST_RUN) && !finish) begin
      nxt_read_stall = 1'b1;
    end else if (want_read) begin
      nxt_read_valid = 1'b1;
      nxt_read_data = read_top_word ? nxt_top : nxt_bottom;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      count_ff <= COUNT_RESET;
      top_ff <= RESULT_RESET;
      bottom_ff <= RESULT_RESET;
      pend_top_ff <= RESULT_RESET;
      pend_bottom_ff <= RESULT_RESET;
      read_valid_ff <= 1'b0;
      read_data_ff <= RESULT_RESET;
      read_stall_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      top_ff <= nxt_top;
      bottom_ff <= nxt_bottom;
      pend_top_ff <= nxt_pend_top;
      pend_bottom_ff <= nxt_pend_bottom;
      read_valid_ff <= nxt_read_valid;
      read_data_ff <= nxt_read_data;
      read_stall_ff <= nxt_read_stall;
      busy_ff <= nxt_busy;
    end
  end

  assign read_valid = read_valid_ff;
  assign read_data = read_data_ff;
  assign read_stall = read_stall_ff;
  assign busy = busy_ff;

  // stall length check helper
  logic [CNT_W-1:0] run_len_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_len_ff <= COUNT_RESET;
    end else if (state_ff == ST_RUN) begin
      run_len_ff <= run_len_ff + 7'd1;
    end else begin
      run_len_ff <= COUNT_RESET;
    end
  end

  // opcode of the operation now running, for stall length checks
  logic [OP_W-1:0] run_op_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_op_ff <= OP_NONE;
    end else if (accept) begin
      run_op_ff <= issue_op;
    end
  end

  double_div_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_UNSIGNED_DOUBLE_QUOTIENT)
    |=> busy [*8])
    else $error("doubleword divide ended too early");
  run_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    run_len_ff <= STALL_DOUBLE_QUOTIENT)
    else $error("operation ran past its stall count");
  dprod_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_SIGNED_DOUBLE_PRODUCT)
    |=> (state_ff == ST_RUN) [*4] ##1 (state_ff == ST_IDLE))
    else $error("doubleword product stall not four cycles");
  wprod_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_SIGNED_WORD_PRODUCT)
    |=> (state_ff == ST_RUN) ##1 (state_ff == ST_IDLE))
    else $error("word product stall not one cycle");
  read_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
    want_read && (state_ff == ST_RUN) && !finish
    |=> read_stall && !read_valid)
    else $error("result read not held during operation");
  read_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    read_bottom_word && !read_top_word && (state_ff == ST_IDLE) && !accept
    |=> read_valid && (read_data == $past(bottom_ff)))
    else $error("bottom word read returned wrong value");
  write_top_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_WRITE_TOP_WORD)
    |=> top_ff == $past(source_a_reg))
    else $error("write of top word lost");
  acc_bottom_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_HALFWORD_ACCUMULATE_BOTTOM_ONLY)
    |=> ##1 top_ff == $past(top_ff, 2))
    else $error("bottom-only accumulate changed top word");
  commit_a: assert property (@(posedge clk) disable iff (!rst_n)
    finish |=> (top_ff == $past(pend_top_ff))
      && (bottom_ff == $past(pend_bottom_ff)))
    else $error("result not committed at finish");
  free_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    want_read && (state_ff == ST_IDLE) |=> read_valid)
    else $error("read stalled with no operation running");

  // the run ends exactly when the opcode's stall count is used up
  stall_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    finish |-> run_len_ff == stall_of(run_op_ff) - 7'd1)
    else $error("operation finished off its stall count");

  // word divide keeps the unit busy for its full count
  wquot_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_SIGNED_WORD_QUOTIENT)
    |=> ##35 (state_ff == ST_IDLE))
    else $error("word divide stall not 35 cycles");

  // doubleword divide: busy 67 cycles, then free
  signed_double_quotient_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_SIGNED_DOUBLE_QUOTIENT)
    |=> busy ##66 busy ##1 !busy)
    else $error("doubleword divide stall not 67 cycles");

  // committed words stay put until the run finishes
  hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == ST_RUN) && !finish
    |=> (top_ff == $past(top_ff)) && (bottom_ff == $past(bottom_ff)))
    else $error("result words changed during an operation");

  // full signed product lands in the pending pair
  sprod_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_SIGNED_DOUBLE_PRODUCT)
    |=> {pend_top_ff, pend_bottom_ff} == 128'($signed($past(source_a_reg))
      * $signed($past(source_b_reg))))
    else $error("signed doubleword product wrong");

  // full unsigned product lands in the pending pair
  uprod_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_UNSIGNED_DOUBLE_PRODUCT)
    |=> {pend_top_ff, pend_bottom_ff} == 128'($past(source_a_reg))
      * 128'($past(source_b_reg)))
    else $error("unsigned doubleword product wrong");

  // unsigned doubleword divide: quotient bottom, remainder top
  udquot_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_UNSIGNED_DOUBLE_QUOTIENT)
      && (source_b_reg != 64'h0)
    |=> (pend_bottom_ff == $past(source_a_reg) / $past(source_b_reg))
      && (pend_top_ff == $past(source_a_reg) % $past(source_b_reg)))
    else $error("unsigned doubleword divide wrong");

  // zero divisor still runs the full count and yields zeros
  zero_div_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_SIGNED_DOUBLE_QUOTIENT)
      && (source_b_reg == 64'h0)
    |=> busy && (pend_top_ff == 64'h0) && (pend_bottom_ff == 64'h0))
    else $error("divide by zero handled wrongly");

  // bottom-only accumulate adds the sign-extended halfword product
  acc_sum_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_HALFWORD_ACCUMULATE_BOTTOM_ONLY)
    |=> pend_bottom_ff == $past(bottom_ff)
      + 64'($signed($past(source_a_reg[HALF_W-1:0]))
      * $signed($past(source_b_reg[HALF_W-1:0]))))
    else $error("bottom-only accumulate sum wrong");

  // write of the bottom word commits on the next edge
  write_bottom_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_WRITE_BOTTOM_WORD)
    |=> bottom_ff == $past(source_a_reg))
    else $error("write of bottom word lost");

  // writes of the result words never start a stall
  write_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && ((issue_op == OP_WRITE_TOP_WORD)
      || (issue_op == OP_WRITE_BOTTOM_WORD))
    |=> !busy)
    else $error("result word write made the unit busy");

  // top word read returns the committed top word
  read_top_a: assert property (@(posedge clk) disable iff (!rst_n)
    read_top_word && (state_ff == ST_IDLE) && !accept
    |=> read_valid && (read_data == $past(top_ff)))
    else $error("top word read returned wrong value");

  // a read in the final run cycle gets the result forwarded
  forward_a: assert property (@(posedge clk) disable iff (!rst_n)
    want_read && finish
    |=> read_valid && (read_data == ($past(read_top_word)
      ? $past(pend_top_ff) : $past(pend_bottom_ff))))
    else $error("read at finish not given the new result");

  // a read is either answered or refused, never both
  excl_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(read_valid && read_stall))
    else $error("read answered and stalled at once");

  div_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_SIGNED_DOUBLE_QUOTIENT));
  stall_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
    read_stall ##1 read_valid);
  acc_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_HALFWORD_PRODUCT_ACCUMULATE));
  wdiv_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
    accept && (issue_op == OP_UNSIGNED_WORD_QUOTIENT));
  fwd_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
    want_read && finish);
endmodule : multiply_divide_unit

// ==== rtl/muldiv_pkg.sv ====
// package of opcodes, widths and stall counts for the multiply/divide unit
// How it works
// - signed doubleword product puts full 128-bit result across top and bottom.
// - unsigned doubleword product puts full 128-bit result across top and bottom.
// - signed doubleword quotient divides a by b as signed 64-bit.
// - unsigned doubleword quotient divides a by b as unsigned 64-bit.
// - doubleword divide: quotient to bottom word, remainder to top word.
// - halfword accumulates sign-extend low 16 bits of each operand first.
// - word-form accumulate adds product to top:bottom pair, 64-bit sum back.
// - bottom-only accumulate adds product to bottom word, top unchanged.
// - result reads after a multiply or divide stall until it finishes.
// - one cycle for word products and accumulates, four for doubleword.
// - 35 cycles for word divides, 67 for doubleword divides.
// - word products use 32-bit operands, 64-bit product to top and bottom.
// - word divide: 32-bit quotient to bottom, 32-bit remainder to top.
// - read-top and read-bottom return the matching result word.
// - write-top and write-bottom load source a into the matching word.
package muldiv_pkg;
  localparam int DATA_W = 64;
  localparam int OP_W = 4;
  localparam int CNT_W = 7;
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;
  // operation codes carried on the issue port
  localparam logic [OP_W-1:0] OP_NONE = 4'h0;
  localparam logic [OP_W-1:0] OP_SIGNED_WORD_PRODUCT = 4'h1;
  localparam logic [OP_W-1:0] OP_UNSIGNED_WORD_PRODUCT = 4'h2;
  localparam logic [OP_W-1:0] OP_SIGNED_WORD_QUOTIENT = 4'h3;
  localparam logic [OP_W-1:0] OP_UNSIGNED_WORD_QUOTIENT = 4'h4;
  localparam logic [OP_W-1:0] OP_SIGNED_DOUBLE_PRODUCT = 4'h5;
  localparam logic [OP_W-1:0] OP_UNSIGNED_DOUBLE_PRODUCT = 4'h6;
  localparam logic [OP_W-1:0] OP_SIGNED_DOUBLE_QUOTIENT = 4'h7;
  localparam logic [OP_W-1:0] OP_UNSIGNED_DOUBLE_QUOTIENT = 4'h8;
  localparam logic [OP_W-1:0] OP_HALFWORD_PRODUCT_ACCUMULATE = 4'h9;
  localparam logic [OP_W-1:0] OP_HALFWORD_ACCUMULATE_BOTTOM_ONLY = 4'ha;
  localparam logic [OP_W-1:0] OP_WRITE_TOP_WORD = 4'hb;
  localparam logic [OP_W-1:0] OP_WRITE_BOTTOM_WORD = 4'hc;
  // stall counts in processor cycles
  localparam logic [CNT_W-1:0] STALL_WORD_PRODUCT = 7'd1;
  localparam logic [CNT_W-1:0] STALL_DOUBLE_PRODUCT = 7'd4;
  localparam logic [CNT_W-1:0] STALL_WORD_QUOTIENT = 7'd35;
  localparam logic [CNT_W-1:0] STALL_DOUBLE_QUOTIENT = 7'd67;
  localparam logic [CNT_W-1:0] STALL_ACCUMULATE = 7'd1;
  // reset values
  localparam logic [DATA_W-1:0] RESULT_RESET = 64'h0;
  localparam logic [CNT_W-1:0] COUNT_RESET = 7'd0;
endpackage : muldiv_pkg

// ==== rtl/muldiv_arith.sv ====
// combinational arithmetic core: products, quotients and accumulates
`timescale 1ns/1ps
module muldiv_arith (
  // operation and operands
  input wire logic [muldiv_pkg::OP_W-1:0] op,
  input wire logic [muldiv_pkg::DATA_W-1:0] src_a,
  input wire logic [muldiv_pkg::DATA_W-1:0] src_b,
  input wire logic [muldiv_pkg::DATA_W-1:0] top_in,
  input wire logic [muldiv_pkg::DATA_W-1:0] bottom_in,
  // results
  output logic [muldiv_pkg::DATA_W-1:0] top_out,
  output logic [muldiv_pkg::DATA_W-1:0] bottom_out
);
  import muldiv_pkg::*;

  // sign-extend a 32-bit value to 64
  function automatic logic [DATA_W-1:0] sext32(input logic [WORD_W-1:0] v);
    sext32 = {{WORD_W{v[WORD_W-1]}}, v};
  endfunction : sext32

  // sign-extend a 16-bit value to 64
  function automatic logic [DATA_W-1:0] sext16(input logic [HALF_W-1:0] v);
    sext16 = {{(DATA_W-HALF_W){v[HALF_W-1]}}, v};
  endfunction : sext16

  logic [2*DATA_W-1:0] prod_s;
  logic [2*DATA_W-1:0] prod_u;
  logic [DATA_W-1:0] wprod_s;
  logic [DATA_W-1:0] wprod_u;
  logic [DATA_W-1:0] hprod;
  logic [DATA_W-1:0] acc_pair;
  logic [DATA_W-1:0] acc_bot;
  logic b_zero;
  logic b_zero_w;

  // full products and halfword product
  always_comb begin
    prod_s = 128'($signed(src_a) * $signed(src_b));
    prod_u = 128'(src_a) * 128'(src_b);
    wprod_s = 64'($signed(sext32(src_a[WORD_W-1:0]))
      * $signed(sext32(src_b[WORD_W-1:0])));
    wprod_u = 64'(src_a[WORD_W-1:0]) * 64'(src_b[WORD_W-1:0]);
    hprod = 64'($signed(sext16(src_a[HALF_W-1:0]))
      * $signed(sext16(src_b[HALF_W-1:0])));
    acc_pair = 64'({top_in[WORD_W-1:0], bottom_in[WORD_W-1:0]}
      + hprod);
    acc_bot = bottom_in + hprod;
    b_zero = (src_b == 64'h0);
    b_zero_w = (src_b[WORD_W-1:0] == 32'h0);
  end

  // select result pair per operation; zero divisor yields zeros (undefined)
  always_comb begin
    top_out = top_in;
    bottom_out = bottom_in;
    unique case (op)
      OP_SIGNED_WORD_PRODUCT: begin
        top_out = sext32(wprod_s[DATA_W-1:WORD_W]);
        bottom_out = sext32(wprod_s[WORD_W-1:0]);
      end
      OP_UNSIGNED_WORD_PRODUCT: begin
        top_out = sext32(wprod_u[DATA_W-1:WORD_W]);
        bottom_out = sext32(wprod_u[WORD_W-1:0]);
      end
      OP_SIGNED_WORD_QUOTIENT: begin
        if (!b_zero_w) begin
          top_out = sext32(32'($signed(src_a[WORD_W-1:0])
            % $signed(src_b[WORD_W-1:0])));
          bottom_out = sext32(32'($signed(src_a[WORD_W-1:0])
            / $signed(src_b[WORD_W-1:0])));
        end else begin
          top_out = 64'h0;
          bottom_out = 64'h0;
        end
      end
      OP_UNSIGNED_WORD_QUOTIENT: begin
        if (!b_zero_w) begin
          top_out = sext32(src_a[WORD_W-1:0] % src_b[WORD_W-1:0]);
          bottom_out = sext32(src_a[WORD_W-1:0] / src_b[WORD_W-1:0]);
        end else begin
          top_out = 64'h0;
          bottom_out = 64'h0;
        end
      end
      OP_SIGNED_DOUBLE_PRODUCT: begin
        top_out = prod_s[2*DATA_W-1:DATA_W];
        bottom_out = prod_s[DATA_W-1:0];
      end
      OP_UNSIGNED_DOUBLE_PRODUCT: begin
        top_out = prod_u[2*DATA_W-1:DATA_W];
        bottom_out = prod_u[DATA_W-1:0];
      end
      OP_SIGNED_DOUBLE_QUOTIENT: begin
        if (!b_zero) begin
          top_out = 64'($signed(src_a) % $signed(src_b));
          bottom_out = 64'($signed(src_a) / $signed(src_b));
        end else begin
          top_out = 64'h0;
          bottom_out = 64'h0;
        end
      end
      OP_UNSIGNED_DOUBLE_QUOTIENT: begin
        if (!b_zero) begin
          top_out = src_a % src_b;
          bottom_out = src_a / src_b;
        end else begin
          top_out = 64'h0;
          bottom_out = 64'h0;
        end
      end
      OP_HALFWORD_PRODUCT_ACCUMULATE: begin
        top_out = sext32(acc_pair[DATA_W-1:WORD_W]);
        bottom_out = sext32(acc_pair[WORD_W-1:0]);
      end
      OP_HALFWORD_ACCUMULATE_BOTTOM_ONLY: begin
        top_out = top_in;
        bottom_out = acc_bot;
      end
      OP_WRITE_TOP_WORD: top_out = src_a;
      OP_WRITE_BOTTOM_WORD: bottom_out = src_a;
      default: begin
        top_out = top_in;
        bottom_out = bottom_in;
      end
    endcase
  end
endmodule : muldiv_arith

// ==== bench/pipeline_model.sv ====
// issuing pipeline model: sends operations and result reads to the unit
`timescale 1ns/1ps
module pipeline_model (
  // clock
  input wire logic clk,
  // issue port
  output logic issue_valid,
  output logic [muldiv_pkg::OP_W-1:0] issue_op,
  output logic [muldiv_pkg::DATA_W-1:0] source_a_reg,
  output logic [muldiv_pkg::DATA_W-1:0] source_b_reg,
  // result read port
  output logic read_top_word,
  output logic read_bottom_word,
  input wire logic read_valid,
  input wire logic [muldiv_pkg::DATA_W-1:0] read_data,
  input wire logic read_stall
);
  import muldiv_pkg::*;
  // idle values from time zero
  initial begin
    issue_valid = 1'b0;
    issue_op = OP_NONE;
    source_a_reg = 64'h0;
    source_b_reg = 64'h0;
    read_top_word = 1'b0;
    read_bottom_word = 1'b0;
  end
  // one-cycle issue pulse; operands scrambled once no longer sampled
  task automatic send_op(input logic [OP_W-1:0] op,
                         input logic [DATA_W-1:0] a, b);
    @(posedge clk);
    #1;
    read_top_word = 1'b0;
    read_bottom_word = 1'b0;
    issue_valid = 1'b1;
    issue_op = op;
    source_a_reg = a;
    source_b_reg = b;
    @(posedge clk);
    #1;
    issue_valid = 1'b0;
    issue_op = ~op;
    source_a_reg = ~a;
    source_b_reg = ~b;
  endtask : send_op
  // read held high until answered, counting refused cycles
  task automatic fetch(input logic top, output logic [DATA_W-1:0] data,
                       output int stalls);
    int i;
    stalls = 999;
    data = 64'h0;
    read_top_word = top;
    read_bottom_word = ~top;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      #1;
      if (read_valid === 1'b1) begin
        stalls = i;
        data = read_data;
        break;
      end
    end
  endtask : fetch
endmodule : pipeline_model

// ==== bench/tb_multiply_divide_unit.sv ====
// self-checking bench for the multiply/divide unit
`timescale 1ns/1ps
module tb_multiply_divide_unit;
  import muldiv_pkg::*;
  typedef struct packed {
    logic [OP_W-1:0] op;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [CNT_W-1:0] n;
  } row_t;
  localparam logic [DATA_W-1:0] T0 = 64'hffff_ffff_ffff_fffe;
  localparam logic [DATA_W-1:0] B0 = 64'h0000_0000_ffff_fff0;
  row_t rows [12] = '{
    '{OP_SIGNED_WORD_PRODUCT, -64'sd7, 64'h5, STALL_WORD_PRODUCT},
    '{OP_UNSIGNED_WORD_PRODUCT, 64'hffff_ffff, 64'h2, STALL_WORD_PRODUCT},
    '{OP_SIGNED_WORD_QUOTIENT, -64'sd7, 64'h2, STALL_WORD_QUOTIENT},
    '{OP_UNSIGNED_WORD_QUOTIENT, 64'hffff_fff9, 64'h2, STALL_WORD_QUOTIENT},
    '{OP_UNSIGNED_WORD_QUOTIENT, 64'h9, 64'h0, STALL_WORD_QUOTIENT},
    '{OP_SIGNED_DOUBLE_PRODUCT, -64'sd3, 64'h7fff_ffff_ffff_ffff,
      STALL_DOUBLE_PRODUCT},
    '{OP_UNSIGNED_DOUBLE_PRODUCT, -64'sd1, -64'sd1, STALL_DOUBLE_PRODUCT},
    '{OP_SIGNED_DOUBLE_QUOTIENT, -64'sd100, 64'h7, STALL_DOUBLE_QUOTIENT},
    '{OP_UNSIGNED_DOUBLE_QUOTIENT, -64'sd1, 64'ha, STALL_DOUBLE_QUOTIENT},
    '{OP_UNSIGNED_DOUBLE_QUOTIENT, 64'h5, 64'h0, STALL_DOUBLE_QUOTIENT},
    '{OP_HALFWORD_PRODUCT_ACCUMULATE, 64'h1234_ffff, 64'h8000,
      STALL_ACCUMULATE},
    '{OP_HALFWORD_ACCUMULATE_BOTTOM_ONLY, 64'h7fff, 64'hffff_8000,
      STALL_ACCUMULATE}};
  logic clk;
  logic rst_n;
  logic issue_valid;
  logic [OP_W-1:0] issue_op;
  logic [DATA_W-1:0] source_a_reg;
  logic [DATA_W-1:0] source_b_reg;
  logic read_top_word;
  logic read_bottom_word;
  logic read_valid;
  logic [DATA_W-1:0] read_data;
  logic read_stall;
  logic busy;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] et;
  logic [DATA_W-1:0] el;
  int s;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  multiply_divide_unit dut (.clk(clk), .rst_n(rst_n),
    .issue_valid(issue_valid), .issue_op(issue_op),
    .source_a_reg(source_a_reg), .source_b_reg(source_b_reg),
    .read_top_word(read_top_word), .read_bottom_word(read_bottom_word),
    .read_valid(read_valid), .read_data(read_data),
    .read_stall(read_stall), .busy(busy));
  pipeline_model pm (.clk(clk), .issue_valid(issue_valid),
    .issue_op(issue_op), .source_a_reg(source_a_reg),
    .source_b_reg(source_b_reg), .read_top_word(read_top_word),
    .read_bottom_word(read_bottom_word), .read_valid(read_valid),
    .read_data(read_data), .read_stall(read_stall));
  function automatic logic [63:0] sx(input logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction : sx
  // reference results: operands widened to 128 bits, then plain arithmetic
  function automatic void ref_op(input row_t r, inout logic [63:0] t,
                                 inout logic [63:0] lo);
    logic wd;
    logic sg;
    logic signed [127:0] x, y, p, q, rm;
    logic [63:0] m;
    wd = r.op < OP_SIGNED_DOUBLE_PRODUCT;
    sg = r.op[0];
    x = wd ? {{96{sg & r.a[31]}}, r.a[31:0]} : {{64{sg & r.a[63]}}, r.a};
    y = wd ? {{96{sg & r.b[31]}}, r.b[31:0]} : {{64{sg & r.b[63]}}, r.b};
    p = x * y;
    q = 0;
    rm = 0;
    if (y != 0) begin
      q = x / y;
      rm = x % y;
    end
    m = $signed(r.a[15:0]) * $signed(r.b[15:0]);
    case (r.op)
      OP_SIGNED_WORD_PRODUCT, OP_UNSIGNED_WORD_PRODUCT: begin
        t = sx(p[63:32]);
        lo = sx(p[31:0]);
      end
      OP_SIGNED_WORD_QUOTIENT, OP_UNSIGNED_WORD_QUOTIENT: begin
        t = sx(rm[31:0]);
        lo = sx(q[31:0]);
      end
      OP_SIGNED_DOUBLE_PRODUCT, OP_UNSIGNED_DOUBLE_PRODUCT: begin
        t = p[127:64];
        lo = p[63:0];
      end
      OP_SIGNED_DOUBLE_QUOTIENT, OP_UNSIGNED_DOUBLE_QUOTIENT: begin
        t = rm[63:0];
        lo = q[63:0];
      end
      OP_HALFWORD_PRODUCT_ACCUMULATE: begin
        m = {t[31:0], lo[31:0]} + m;
        t = sx(m[63:32]);
        lo = sx(m[31:0]);
      end
      default: lo = lo + m;
    endcase
  endfunction : ref_op
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check({busy, read_valid, read_stall}, 64'h0);
    for (int i = 0; i < 12; i++) begin
      pm.send_op(OP_WRITE_TOP_WORD, T0, 64'h0);
      pm.send_op(OP_WRITE_BOTTOM_WORD, B0, 64'h0);
      et = T0;
      el = B0;
      ref_op(rows[i], et, el);
      pm.send_op(rows[i].op, rows[i].a, rows[i].b);
      pm.fetch(1'b1, d, s);
      check(d, et);
      check(64'(s), 64'(rows[i].n) - 64'h1);
      pm.fetch(1'b0, d, s);
      check(d, el);
      check(64'(s), 64'h0);
    end
    // issue while a divide runs is ignored
    pm.send_op(OP_WRITE_TOP_WORD, T0, 64'h0);
    pm.send_op(rows[7].op, rows[7].a, rows[7].b);
    pm.send_op(OP_WRITE_TOP_WORD, 64'h55, 64'h0);
    pm.fetch(1'b1, d, s);
    check(d, 64'hffff_ffff_ffff_fffe);
    check(64'(s), 64'(STALL_DOUBLE_QUOTIENT) - 64'h3);
    // reset in mid-run clears the stall and the bottom word (top word not checked)
    pm.send_op(rows[7].op, rows[7].a, rows[7].b);
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    check({busy, read_valid, read_stall}, 64'h0);
    pm.fetch(1'b0, d, s);
    check(d, RESULT_RESET);
    check(64'(s), 64'h0);
    complete_run();
  end
endmodule : tb_multiply_divide_unit
